//--- src/pcmbcd_consts.svh
// register map, field positions and reset values of the pin change mask block
`ifndef PCMBCD_CONSTS_SVH
`define PCMBCD_CONSTS_SVH

`define PCMBCD_ADDR_W 12
`define PCMBCD_DATA_W 32
`define PCMBCD_PINS 8
`define PCMBCD_GROUPS 3

// register indices; the byte address is four times the index
`define PCMBCD_IDX_MASK_B 12'h06b
`define PCMBCD_IDX_MASK_C 12'h06c
`define PCMBCD_IDX_MASK_D 12'h06d
`define PCMBCD_IDX_CTRL 12'h068
`define PCMBCD_IDX_FLAG 12'h03b
`define PCMBCD_BYTE_ADDR(idx) (12'((idx) << 2))

`define PCMBCD_MASK_RESET 8'h00
`define PCMBCD_CTRL_RESET 8'h00
`define PCMBCD_FLAG_RESET 1'b0

// control register fields: group enables in the low bits, global enable on top
`define PCMBCD_CTRL_GRP_LSB 0
`define PCMBCD_CTRL_GIE_BIT 7
`define PCMBCD_CTRL_WMASK 8'h87

// group numbering inside the enable and flag fields
`define PCMBCD_GRP_B 0
`define PCMBCD_GRP_C 1
`define PCMBCD_GRP_D 2

`endif

//--- src/pcmbcd_pkg.sv
// types shared by the pin change mask block
package pcmbcd_pkg;
	typedef logic [7:0] pcmbcd_mask_t;
	typedef logic [2:0] pcmbcd_grp_t;
	// register selected by the current bus address
	typedef enum logic [2:0] {
		pcmbcd_sel_none,
		pcmbcd_sel_mask_b,
		pcmbcd_sel_mask_c,
		pcmbcd_sel_mask_d,
		pcmbcd_sel_ctrl,
		pcmbcd_sel_flag
	} pcmbcd_sel_t;
endpackage : pcmbcd_pkg

//--- src/pcmbcd_port_detect.sv
// per-port level change detector: sample, compare with previous, mask and merge
`timescale 1ns/1ps
`default_nettype none
module pcmbcd_port_detect
	import pcmbcd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire pcmbcd_mask_t pin_level,
	input wire pcmbcd_mask_t pin_mask,
	output logic change_pulse_r
);
	pcmbcd_mask_t sample_r;
	pcmbcd_mask_t prev_r;
	logic [1:0] primed_r;
	pcmbcd_mask_t diff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_r <= 8'h00;
			prev_r <= 8'h00;
		end else begin
			sample_r <= pin_level;
			prev_r <= sample_r;
		end
	end

	// no change is reported until two real samples exist, so a pin high at reset is quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primed_r <= 2'b00;
		end else begin
			primed_r <= {primed_r[0], 1'b1};
		end
	end

	assign diff = (sample_r ^ prev_r) & {8{primed_r[1]}};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			change_pulse_r <= 1'b0;
		end else begin
			change_pulse_r <= |(diff & pin_mask);
		end
	end

	masked_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pin_mask == 8'h00) |=> !change_pulse_r)
		else $error("change reported with every pin masked");

	edge_both_a: assert property (@(posedge pclk) disable iff (!presetn)
		(primed_r[1] && ((sample_r ^ prev_r) & pin_mask) != 8'h00) |=> change_pulse_r)
		else $error("enabled pin toggle not reported");

	fall_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
		primed_r[1] && ((prev_r & ~sample_r & pin_mask) != 8'h00));
endmodule : pcmbcd_port_detect
`default_nettype wire

//--- src/pcmbcd_flag.sv
// sticky group flag: set by a change, cleared by write-one or service entry
`include "pcmbcd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pcmbcd_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_pulse,
	input wire logic clr_write,
	input wire logic clr_isr,
	output logic flag_r
);
	// set wins over clear so a change landing in the clearing cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= `PCMBCD_FLAG_RESET;
		end else if (set_pulse) begin
			flag_r <= 1'b1;
		end else if (clr_write || clr_isr) begin
			flag_r <= 1'b0;
		end
	end
endmodule : pcmbcd_flag
`default_nettype wire

//--- src/pcmbcd_top.sv
// pin change interrupt masks for ports b, c and d with apb register access
`include "pcmbcd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pcmbcd_top
	import pcmbcd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PCMBCD_ADDR_W-1:0] paddr,
	input wire logic [`PCMBCD_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [`PCMBCD_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pcmbcd_mask_t port_b_pins,
	input wire pcmbcd_mask_t port_c_pins,
	input wire pcmbcd_mask_t port_d_pins,
	input wire pcmbcd_grp_t isr_enter,
	output logic group_b_irq,
	output logic group_c_irq,
	output logic group_d_irq,
	output logic irq,
	output logic wake_request
);
	pcmbcd_mask_t port_b_change_mask_r;
	pcmbcd_mask_t port_c_change_mask_r;
	pcmbcd_mask_t port_d_change_mask_r;
	logic [7:0] ctrl_r;
	logic [`PCMBCD_DATA_W-1:0] prdata_r;
	logic [`PCMBCD_DATA_W-1:0] prdata_nxt;
	logic pready_r;
	logic pslverr_r;
	pcmbcd_sel_t sel;
	logic setup_phase;
	logic write_take;
	logic low_lane;
	pcmbcd_grp_t change_pulse;
	pcmbcd_grp_t flag_vec;
	pcmbcd_grp_t group_enable;
	logic global_enable;
	pcmbcd_grp_t w1c;
	pcmbcd_grp_t group_irq_r;
	logic irq_r;
	logic wake_r;

	// address decode
	always_comb begin
		case (paddr)
			`PCMBCD_BYTE_ADDR(`PCMBCD_IDX_MASK_B): sel = pcmbcd_sel_mask_b;
			`PCMBCD_BYTE_ADDR(`PCMBCD_IDX_MASK_C): sel = pcmbcd_sel_mask_c;
			`PCMBCD_BYTE_ADDR(`PCMBCD_IDX_MASK_D): sel = pcmbcd_sel_mask_d;
			`PCMBCD_BYTE_ADDR(`PCMBCD_IDX_CTRL): sel = pcmbcd_sel_ctrl;
			`PCMBCD_BYTE_ADDR(`PCMBCD_IDX_FLAG): sel = pcmbcd_sel_flag;
			default: sel = pcmbcd_sel_none;
		endcase
	end

	assign setup_phase = psel && !penable;
	// writes land only at the edge where the access phase meets pready
	assign write_take = psel && penable && pready_r && pwrite && (sel != pcmbcd_sel_none);
	// all registers fit in 8 bits, so only byte lane 0 carries data
	assign low_lane = pstrb[0];

	// zero wait state: ready rises in the access cycle right after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup_phase;
		end
	end

	// unmapped addresses answer with an error and read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= setup_phase && (sel == pcmbcd_sel_none);
		end
	end

	always_comb begin
		prdata_nxt = 32'h0000_0000;
		case (sel)
			pcmbcd_sel_mask_b: prdata_nxt[7:0] = port_b_change_mask_r;
			pcmbcd_sel_mask_c: prdata_nxt[7:0] = port_c_change_mask_r;
			pcmbcd_sel_mask_d: prdata_nxt[7:0] = port_d_change_mask_r;
			pcmbcd_sel_ctrl: prdata_nxt[7:0] = ctrl_r;
			pcmbcd_sel_flag: prdata_nxt[2:0] = flag_vec;
			default: prdata_nxt = 32'h0000_0000;
		endcase
	end

	// read data is captured in setup and held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_r <= pwrite ? 32'h0000_0000 : prdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_b_change_mask_r <= `PCMBCD_MASK_RESET;
		end else if (write_take && low_lane && sel == pcmbcd_sel_mask_b) begin
			port_b_change_mask_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_c_change_mask_r <= `PCMBCD_MASK_RESET;
		end else if (write_take && low_lane && sel == pcmbcd_sel_mask_c) begin
			port_c_change_mask_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_d_change_mask_r <= `PCMBCD_MASK_RESET;
		end else if (write_take && low_lane && sel == pcmbcd_sel_mask_d) begin
			port_d_change_mask_r <= pwdata[7:0];
		end
	end

	// group enables and global enable; reserved bits stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `PCMBCD_CTRL_RESET;
		end else if (write_take && low_lane && sel == pcmbcd_sel_ctrl) begin
			ctrl_r <= pwdata[7:0] & `PCMBCD_CTRL_WMASK;
		end
	end

	assign group_enable = ctrl_r[`PCMBCD_CTRL_GRP_LSB +: `PCMBCD_GROUPS];
	assign global_enable = ctrl_r[`PCMBCD_CTRL_GIE_BIT];

	assign w1c = (write_take && low_lane && sel == pcmbcd_sel_flag) ? pwdata[2:0] : 3'h0;

	pcmbcd_port_detect u_det_b (
		.pclk(pclk),
		.presetn(presetn),
		.pin_level(port_b_pins),
		.pin_mask(port_b_change_mask_r),
		.change_pulse_r(change_pulse[`PCMBCD_GRP_B])
	);

	pcmbcd_port_detect u_det_c (
		.pclk(pclk),
		.presetn(presetn),
		.pin_level(port_c_pins),
		.pin_mask(port_c_change_mask_r),
		.change_pulse_r(change_pulse[`PCMBCD_GRP_C])
	);

	pcmbcd_port_detect u_det_d (
		.pclk(pclk),
		.presetn(presetn),
		.pin_level(port_d_pins),
		.pin_mask(port_d_change_mask_r),
		.change_pulse_r(change_pulse[`PCMBCD_GRP_D])
	);

	genvar g;
	generate
		for (g = 0; g < `PCMBCD_GROUPS; g++) begin : gen_flag
			pcmbcd_flag u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set_pulse(change_pulse[g]),
				.clr_write(w1c[g]),
				.clr_isr(isr_enter[g]),
				.flag_r(flag_vec[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_irq_r <= 3'h0;
		end else begin
			group_irq_r <= flag_vec & group_enable & {3{global_enable}};
		end
	end

	// combined level output, same gating as the group requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(flag_vec & group_enable) && global_enable;
		end
	end

	// wake on change
	// the power manager keeps the clock alive while it watches this; no enable gates it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= |change_pulse;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign group_b_irq = group_irq_r[`PCMBCD_GRP_B];
	assign group_c_irq = group_irq_r[`PCMBCD_GRP_C];
	assign group_d_irq = group_irq_r[`PCMBCD_GRP_D];
	assign irq = irq_r;
	assign wake_request = wake_r;

	mask_b_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(write_take && low_lane && sel == pcmbcd_sel_mask_b)
		|=> (port_b_change_mask_r == $past(pwdata[7:0])))
		else $error("port b mask did not take written value");

	mask_c_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(write_take && low_lane && sel == pcmbcd_sel_mask_c)
		|=> (port_c_change_mask_r == $past(pwdata[7:0])))
		else $error("port c mask did not take written value");

	mask_d_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(write_take && low_lane && sel == pcmbcd_sel_mask_d)
		|=> (port_d_change_mask_r == $past(pwdata[7:0])))
		else $error("port d mask did not take written value");

	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		change_pulse[`PCMBCD_GRP_C] |=> flag_vec[`PCMBCD_GRP_C])
		else $error("port c change did not set its group flag");

	// gating of requests, one cycle from flag to output
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		group_b_irq |-> ($past(flag_vec[`PCMBCD_GRP_B]) && $past(group_enable[`PCMBCD_GRP_B])
		&& $past(global_enable)))
		else $error("group b request without flag and both enables");

	irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_vec[`PCMBCD_GRP_D] && group_enable[`PCMBCD_GRP_D] && global_enable)
		|=> group_d_irq)
		else $error("group d request missing");

	// mask reads back through the bus
	mask_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !pwrite && sel == pcmbcd_sel_mask_b)
		|=> (prdata_r == {24'h00_0000, $past(port_b_change_mask_r)}))
		else $error("port b mask read returned wrong data");

	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(isr_enter[`PCMBCD_GRP_B] && !change_pulse[`PCMBCD_GRP_B])
		|=> !flag_vec[`PCMBCD_GRP_B])
		else $error("group b flag not cleared on service entry");

	// set wins over a same-cycle clear
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(change_pulse[`PCMBCD_GRP_D] && w1c[`PCMBCD_GRP_D]) |=> flag_vec[`PCMBCD_GRP_D])
		else $error("change lost against write-one clear");

	wake_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|change_pulse) |=> wake_request)
		else $error("wake request missing after pin change");

	// bus answers one cycle after setup
	ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase |=> pready)
		else $error("pready late");

	flag_set_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(flag_vec[`PCMBCD_GRP_B]));
	irq_raise_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(irq));
	w1c_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
		w1c != 3'h0 ##1 flag_vec == 3'h0);
	isr_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
		(isr_enter != 3'h0) && (flag_vec != 3'h0));
endmodule : pcmbcd_top
`default_nettype wire

//--- dv/pcmbcd_far_model.sv
// port pads and processor interrupt entry facing the pin change block
`timescale 1ns/1ps
`default_nettype none
module pcmbcd_far_model
	import pcmbcd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire pcmbcd_mask_t tog_b,
	input wire pcmbcd_mask_t tog_c,
	input wire pcmbcd_mask_t tog_d,
	input wire logic auto_ack,
	input wire pcmbcd_grp_t grp_irq,
	output var pcmbcd_mask_t port_b_pins,
	output var pcmbcd_mask_t port_c_pins,
	output var pcmbcd_mask_t port_d_pins,
	output var pcmbcd_grp_t isr_enter
);
	pcmbcd_grp_t seen_r;
	initial begin
		port_b_pins = 8'h00;
		port_c_pins = 8'h00;
		port_d_pins = 8'h00;
		isr_enter = 3'h0;
		seen_r = 3'h0;
	end
	// pads are outside levels, so they keep their value through a reset
	always @(posedge pclk) begin
		port_b_pins <= port_b_pins ^ tog_b;
		port_c_pins <= port_c_pins ^ tog_c;
		port_d_pins <= port_d_pins ^ tog_d;
	end
	// the processor enters a service routine once per newly raised request
	always @(posedge pclk) begin
		seen_r <= presetn ? grp_irq : 3'h0;
		isr_enter <= auto_ack ? (grp_irq & ~seen_r) : 3'h0;
	end
endmodule : pcmbcd_far_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench of the pin change mask block
`include "pcmbcd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pcmbcd_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, gb, gc, gd, irq, wake, auto_ack = 1'b0;
	pcmbcd_mask_t pb, pc, pd, tog [3] = '{8'h00, 8'h00, 8'h00};
	pcmbcd_grp_t isr;
	int fails = 0, n_compared = 0, wakes = 0, isrs = 0, flg = 0, ct = 0;
	int m [3];
	int cl [7] = '{32'h07, 32'h80, 32'h81, 32'h82, 32'h84, 32'h87, 32'hff};
	logic [31:0] rs = 32'h7074649f;
	logic [11:0] idx [3] = '{`PCMBCD_IDX_MASK_B, `PCMBCD_IDX_MASK_C, `PCMBCD_IDX_MASK_D};
	always #5 pclk = ~pclk;
	pcmbcd_top pcmbcd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_b_pins(pb), .port_c_pins(pc),
		.port_d_pins(pd), .isr_enter(isr), .group_b_irq(gb), .group_c_irq(gc),
		.group_d_irq(gd), .irq(irq), .wake_request(wake));
	pcmbcd_far_model pcmbcd_far_model_inst (.pclk(pclk), .presetn(presetn), .tog_b(tog[0]),
		.tog_c(tog[1]), .tog_d(tog[2]), .auto_ack(auto_ack), .grp_irq({gd, gc, gb}),
		.port_b_pins(pb), .port_c_pins(pc), .port_d_pins(pd), .isr_enter(isr));
	always @(posedge pclk) begin
		if (wake === 1'b1) wakes++;
		if (isr !== 3'h0) isrs++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic er);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) chk("pready", 32'h1, 32'h0);
	endtask : apb
	task automatic rchk(input string nm, input logic [11:0] i, input logic [31:0] e);
		logic [31:0] q;
		logic er;
		apb(1'b0, `PCMBCD_BYTE_ADDR(i), 32'h0, 4'h0, q, er);
		chk(nm, e, q);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask : rchk
	task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		logic er;
		apb(1'b1, `PCMBCD_BYTE_ADDR(i), d, s, q, er);
	endtask : wr
	task automatic chkirq();
		int g;
		g = ((ct >> 7) & 1) ? (flg & ct & 7) : 0;
		chk("group_irqs", 32'(g), {29'h0, gd, gc, gb});
		chk("irq", 32'(g != 0), {31'h0, irq});
	endtask : chkirq
	// one pin event on port p, then flags, wake and requests against the model
	task automatic ev(input int p, input pcmbcd_mask_t t);
		int w0;
		w0 = wakes;
		@(posedge pclk);
		tog[p] <= t;
		@(posedge pclk);
		tog[p] <= 8'h00;
		repeat (8) @(posedge pclk);
		if ((t & m[p]) != 0) flg = flg | (1 << p);
		chk("wake", 32'((t & m[p]) != 0), 32'(wakes != w0));
		rchk("flags", `PCMBCD_IDX_FLAG, 32'(flg));
		chkirq();
	endtask : ev
	task automatic clr(input int v);
		wr(`PCMBCD_IDX_FLAG, 32'(v), 4'hf);
		flg = flg & ~v;
		repeat (3) @(posedge pclk);
		chkirq();
	endtask : clr
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		repeat (50000) @(posedge pclk);
		fails++;
		finish_test();
	end
	initial begin
		logic [31:0] q;
		logic er;
		int w0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int p = 0; p < 3; p++) rchk("mask", idx[p], 32'h0);
		rchk("ctrl", `PCMBCD_IDX_CTRL, 32'h0);
		rchk("flags", `PCMBCD_IDX_FLAG, 32'h0);
		apb(1'b0, 12'h004, 32'h0, 4'h0, q, er);
		chk("unmapped", 32'h1, {31'h0, er});
		wr(idx[0], 32'hff, 4'h0);
		rchk("mask_strb", idx[0], 32'h0);
		for (int p = 0; p < 3; p++) begin
			rs = lfsr(rs);
			m[p] = int'(rs[7:0]);
			wr(idx[p], rs, 4'hf);
			rchk("mask", idx[p], 32'(m[p]));
		end
		ct = 32'h87;
		wr(`PCMBCD_IDX_CTRL, 32'h87, 4'hf);
		// every pin, both edges, masked neighbours
		for (int p = 0; p < 3; p++)
			for (int n = 0; n < 8; n++) begin
				m[p] = 1 << n;
				wr(idx[p], 32'(m[p]), 4'hf);
				ev(p, ~pcmbcd_mask_t'(m[p]));
				rs = lfsr(rs);
				ev(p, rs[7:0]);
				clr(7);
				ev(p, pcmbcd_mask_t'(m[p]));
				clr(1 << p);
				ev(p, pcmbcd_mask_t'(m[p]));
				clr(7);
			end
		for (int p = 0; p < 3; p++) begin
			m[p] = 255;
			wr(idx[p], 32'hff, 4'hf);
		end
		foreach (cl[i]) begin
			wr(`PCMBCD_IDX_CTRL, 32'(cl[i]), 4'hf);
			ct = cl[i] & 32'h87;
			rchk("ctrl", `PCMBCD_IDX_CTRL, 32'(ct));
			for (int p = 0; p < 3; p++) ev(p, 8'h80);
			clr(2);
			clr(7);
		end
		// a change landing with the write-one clear keeps the flag
		@(posedge pclk);
		tog[2] <= 8'h01;
		@(posedge pclk);
		tog[2] <= 8'h00;
		wr(`PCMBCD_IDX_FLAG, 32'h4, 4'hf);
		flg = 4;
		repeat (4) @(posedge pclk);
		rchk("flag_set_wins", `PCMBCD_IDX_FLAG, 32'h4);
		chkirq();
		clr(4);
		// service entry clears the flag of every group
		auto_ack <= 1'b1;
		for (int p = 0; p < 3; p++) begin
			w0 = isrs;
			@(posedge pclk);
			tog[p] <= 8'h01;
			@(posedge pclk);
			tog[p] <= 8'h00;
			repeat (12) @(posedge pclk);
			chk("isr_count", 32'h1, 32'(isrs - w0));
			rchk("flags", `PCMBCD_IDX_FLAG, 32'h0);
			chkirq();
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		ct = 0;
		flg = 0;
		for (int p = 0; p < 3; p++) rchk("mask", idx[p], 32'h0);
		rchk("ctrl", `PCMBCD_IDX_CTRL, 32'h0);
		rchk("flags", `PCMBCD_IDX_FLAG, 32'h0);
		chkirq();
		chk("wake", 32'h0, {31'h0, wake});
		finish_test();
	end
endmodule : testbench
`default_nettype wire
